// File: rtl/sdwpr_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdwpr_params.svh"
module sdwpr_core
    import sdwpr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic cke,
    input wire sdwpr_cmd_pins_t cmd_pins,
    input wire sdwpr_wbeat_t wbeat,
    input wire logic otf_enable,
    input wire logic fixed_chop,
    output logic wbuf_in_ready,
    output logic arr_valid,
    input wire logic arr_ready,
    output sdwpr_arr_wr_t arr_wr,
    output logic [`SDWPR_NBANK-1:0] bank_open,
    output logic write_busy,
    output logic refresh_busy,
    output logic refresh_pulse,
    output logic [`SDWPR_REF_ROW_W-1:0] refresh_row,
    output logic self_refresh
);

    function automatic sdwpr_cmd_t decode_cmd(input sdwpr_cmd_pins_t p);
        logic [2:0] s;
        s = {p.ras_n, p.cas_n, p.we_n};
        if (p.cs_n) begin
            decode_cmd = SDWPR_CMD_NONE;
        end else begin
            case (s)
                3'h3: decode_cmd = SDWPR_CMD_ACT;
                3'h4: decode_cmd = SDWPR_CMD_WR;
                3'h2: decode_cmd = SDWPR_CMD_PRE;
                3'h1: decode_cmd = SDWPR_CMD_REF;
                default: decode_cmd = SDWPR_CMD_NONE;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    sdwpr_cmd_t cmd;
    logic cke_q;
    logic cmd_live;
    logic ap_bit;
    logic sr_entry;

    assign cmd = decode_cmd(cmd_pins);
    assign cmd_live = cke && cke_q && !self_refresh;
    assign ap_bit = cmd_pins.addr[`SDWPR_AP_BIT];
    assign sr_entry = cke_q && !cke && !self_refresh && (cmd == SDWPR_CMD_REF);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= cke;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write burst
    logic burst_q, burst_d;
    logic [3:0] beats_q, beats_d;
    logic [2:0] wbank_q, wbank_d;
    logic [`SDWPR_COL_MSB:0] wcol_q, wcol_d;
    logic wap_q, wap_d;
    logic wr_take;
    logic burst_end;
    logic push;
    sdwpr_bank_st_t bank_st_q [`SDWPR_NBANK];
    sdwpr_bank_st_t bank_st_d [`SDWPR_NBANK];
    logic [`SDWPR_ROW_W-1:0] row_q [`SDWPR_NBANK];
    logic [`SDWPR_ROW_W-1:0] row_d [`SDWPR_NBANK];

    assign wr_take = cmd_live && (cmd == SDWPR_CMD_WR) && !burst_q
        && (bank_st_q[cmd_pins.ba] == SDWPR_BANK_ACTIVE);
    assign burst_end = burst_q && (beats_q == 4'h1);
    assign push = burst_q && !wbeat.write_byte_mask && wbuf_in_ready;

    always_comb begin
        burst_d = burst_q;
        beats_d = beats_q;
        wbank_d = wbank_q;
        wcol_d = wcol_q;
        wap_d = wap_q;
        if (wr_take) begin
            burst_d = 1'b1;
            wbank_d = cmd_pins.ba;
            wcol_d = cmd_pins.addr[`SDWPR_COL_MSB:0];
            wap_d = ap_bit;
            if (otf_enable) begin
                beats_d = cmd_pins.addr[`SDWPR_BL_BIT] ? `SDWPR_BEATS_FULL
                    : `SDWPR_BEATS_CHOP;
            end else begin
                beats_d = fixed_chop ? `SDWPR_BEATS_CHOP : `SDWPR_BEATS_FULL;
            end
        end else if (burst_q) begin
            beats_d = beats_q - 4'h1;
            wcol_d = wcol_q + 10'h001;
            if (burst_end) begin
                burst_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            burst_q <= 1'b0;
            beats_q <= 4'h0;
            wbank_q <= 3'h0;
            wcol_q <= 10'h000;
            wap_q <= 1'b0;
        end else begin
            burst_q <= burst_d;
            beats_q <= beats_d;
            wbank_q <= wbank_d;
            wcol_q <= wcol_d;
            wap_q <= wap_d;
        end
    end

    assign write_busy = burst_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bank state and precharge timing
    logic [3:0] rp_q [`SDWPR_NBANK];
    logic [3:0] rp_d [`SDWPR_NBANK];

    always_comb begin
        for (int b = 0; b < `SDWPR_NBANK; b++) begin
            bank_st_d[b] = bank_st_q[b];
            row_d[b] = row_q[b];
            rp_d[b] = rp_q[b];
            if (bank_st_q[b] == SDWPR_BANK_PRECHG) begin
                if (rp_q[b] <= 4'h1) begin
                    bank_st_d[b] = SDWPR_BANK_IDLE;
                    rp_d[b] = 4'h0;
                end else begin
                    rp_d[b] = rp_q[b] - 4'h1;
                end
            end
            if (burst_end && wap_q && (wbank_q == b[2:0])) begin
                bank_st_d[b] = SDWPR_BANK_PRECHG;
                rp_d[b] = 4'(`SDWPR_RP_CYC);
            end
            if (cmd_live && (cmd == SDWPR_CMD_PRE)
                && (ap_bit || (cmd_pins.ba == b[2:0]))) begin
                rp_d[b] = 4'(`SDWPR_RP_CYC);
                if (bank_st_q[b] != SDWPR_BANK_IDLE) begin
                    bank_st_d[b] = SDWPR_BANK_PRECHG;
                end
            end
            if (cmd_live && (cmd == SDWPR_CMD_ACT) && (cmd_pins.ba == b[2:0])
                && (bank_st_q[b] == SDWPR_BANK_IDLE)) begin
                bank_st_d[b] = SDWPR_BANK_ACTIVE;
                row_d[b] = cmd_pins.addr;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int b = 0; b < `SDWPR_NBANK; b++) begin
                bank_st_q[b] <= SDWPR_BANK_IDLE;
                row_q[b] <= '0;
                rp_q[b] <= 4'h0;
            end
        end else begin
            for (int b = 0; b < `SDWPR_NBANK; b++) begin
                bank_st_q[b] <= bank_st_d[b];
                row_q[b] <= row_d[b];
                rp_q[b] <= rp_d[b];
            end
        end
    end

    always_comb begin
        for (int b = 0; b < `SDWPR_NBANK; b++) begin
            bank_open[b] = (bank_st_q[b] == SDWPR_BANK_ACTIVE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Refresh and self refresh
    logic [3:0] rfc_q, rfc_d;
    logic [`SDWPR_REF_ROW_W-1:0] rrow_q, rrow_d;
    logic sr_q, sr_d;
    logic [8:0] srt_q, srt_d;
    logic rpulse_q, rpulse_d;
    logic do_ref;

    assign do_ref = (cmd_live && (cmd == SDWPR_CMD_REF)) || sr_entry
        || (sr_q && (srt_q == 9'h000));

    always_comb begin
        rfc_d = (rfc_q != 4'h0) ? rfc_q - 4'h1 : 4'h0;
        rrow_d = rrow_q;
        sr_d = sr_q;
        srt_d = srt_q;
        rpulse_d = do_ref;
        if (do_ref) begin
            rrow_d = rrow_q + 13'h0001;
            rfc_d = 4'(`SDWPR_RFC_CYC);
        end
        if (sr_entry) begin
            sr_d = 1'b1;
            srt_d = 9'(`SDWPR_SR_REF_CYC - 1);
        end else if (sr_q) begin
            srt_d = (srt_q == 9'h000) ? 9'(`SDWPR_SR_REF_CYC - 1) : srt_q - 9'h001;
            if (cke) begin
                sr_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rfc_q <= 4'h0;
            rrow_q <= 13'h0000;
            sr_q <= 1'b0;
            srt_q <= 9'h000;
            rpulse_q <= 1'b0;
        end else begin
            rfc_q <= rfc_d;
            rrow_q <= rrow_d;
            sr_q <= sr_d;
            srt_q <= srt_d;
            rpulse_q <= rpulse_d;
        end
    end

    assign refresh_busy = (rfc_q != 4'h0);
    assign refresh_row = rrow_q;
    assign refresh_pulse = rpulse_q;
    assign self_refresh = sr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry write buffer toward the array
    sdwpr_arr_wr_t buf_q [2];
    sdwpr_arr_wr_t buf_d [2];
    logic wp_q, wp_d, rp_ptr_q, rp_ptr_d;
    logic [1:0] cnt_q, cnt_d;
    logic pop;

    assign wbuf_in_ready = (cnt_q != 2'h2);
    assign arr_valid = (cnt_q != 2'h0);
    assign pop = arr_valid && arr_ready;
    assign arr_wr = buf_q[rp_ptr_q];

    always_comb begin
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        wp_d = wp_q;
        rp_ptr_d = rp_ptr_q;
        cnt_d = cnt_q;
        if (push) begin
            buf_d[wp_q] = '{bank: wbank_q, row: row_q[wbank_q], col: wcol_q,
                data: wbeat.data};
            wp_d = ~wp_q;
        end
        if (pop) begin
            rp_ptr_d = ~rp_ptr_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wp_q <= 1'b0;
            rp_ptr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            buf_q[0] <= buf_d[0];
            buf_q[1] <= buf_d[1];
            wp_q <= wp_d;
            rp_ptr_q <= rp_ptr_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_refresh_row_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
        do_ref |=> (refresh_row == $past(refresh_row) + 13'h0001) && refresh_pulse)
        else $error("refresh row did not advance by one");

    chk_precharge_all_close: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cmd_live && cmd == SDWPR_CMD_PRE && ap_bit) |=> (bank_open == 8'h00))
        else $error("precharge all left a bank open");

    chk_precharge_one_bank: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cmd_live && cmd == SDWPR_CMD_PRE && !ap_bit && !(burst_end && wap_q))
        |=> (bank_open == ($past(bank_open) & ~(8'h01 << $past(cmd_pins.ba)))))
        else $error("single precharge touched the wrong banks");

    chk_masked_beat_skip: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (burst_q && wbeat.write_byte_mask && !pop) |=> (cnt_q == $past(cnt_q)))
        else $error("masked beat was stored");

    chk_burst_chop_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wr_take && otf_enable && !cmd_pins.addr[`SDWPR_BL_BIT])
        |=> burst_q [*4] ##1 !burst_q)
        else $error("chopped burst did not last four beats");

    chk_write_bank_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wr_take |=> (wbank_q == $past(cmd_pins.ba)) && (wap_q == $past(ap_bit)))
        else $error("write bank or precharge mode not captured");

    chk_auto_precharge: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (burst_end && wap_q) |=> !bank_open[$past(wbank_q)])
        else $error("auto precharge left the row open");

    chk_deselect_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (cmd_pins.cs_n && !burst_end) |=> (bank_open == $past(bank_open)) && !refresh_pulse
        || $past(sr_q))
        else $error("deselect changed bank state");

    chk_selfref_entry: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sr_entry |=> self_refresh ##[1:390] refresh_pulse || !self_refresh)
        else $error("self refresh did not refresh internally");

endmodule
`default_nettype wire

// File: rtl/sdwpr_params.svh
`ifndef SDWPR_PARAMS_SVH
`define SDWPR_PARAMS_SVH

// Clock and timing
`define SDWPR_CLK_MHZ 50
`define SDWPR_RP_NS 15
`define SDWPR_RP_CYC ((`SDWPR_RP_NS * `SDWPR_CLK_MHZ + 999) / 1000)
`define SDWPR_RFC_NS 160
`define SDWPR_RFC_CYC ((`SDWPR_RFC_NS * `SDWPR_CLK_MHZ + 999) / 1000)
`define SDWPR_REFI_NS 7800
`define SDWPR_SR_REF_CYC ((`SDWPR_REFI_NS * `SDWPR_CLK_MHZ) / 1000)

// Address bit positions
`define SDWPR_AP_BIT 10
`define SDWPR_BL_BIT 12
`define SDWPR_COL_MSB 9

// Burst lengths
`define SDWPR_BEATS_CHOP 4'h4
`define SDWPR_BEATS_FULL 4'h8

// Widths
`define SDWPR_ADDR_W 14
`define SDWPR_ROW_W 14
`define SDWPR_DQ_W 8
`define SDWPR_NBANK 8
`define SDWPR_REF_ROW_W 13

`endif

// File: rtl/sdwpr_pkg.sv
`include "sdwpr_params.svh"

package sdwpr_pkg;

    typedef enum {
        SDWPR_CMD_NONE,
        SDWPR_CMD_ACT,
        SDWPR_CMD_WR,
        SDWPR_CMD_PRE,
        SDWPR_CMD_REF
    } sdwpr_cmd_t;

    typedef enum {
        SDWPR_BANK_IDLE,
        SDWPR_BANK_ACTIVE,
        SDWPR_BANK_PRECHG
    } sdwpr_bank_st_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [`SDWPR_ADDR_W-1:0] addr;
    } sdwpr_cmd_pins_t;

    typedef struct packed {
        logic [`SDWPR_DQ_W-1:0] data;
        logic write_byte_mask;
    } sdwpr_wbeat_t;

    typedef struct packed {
        logic [2:0] bank;
        logic [`SDWPR_ROW_W-1:0] row;
        logic [`SDWPR_COL_MSB:0] col;
        logic [`SDWPR_DQ_W-1:0] data;
    } sdwpr_arr_wr_t;

endpackage

// File: tb/sdwpr_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdwpr_params.svh"
module sdwpr_core_tb_top
    import sdwpr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic otf_enable = 1'b1;
    logic fixed_chop = 1'b0;
    logic arr_ready = 1'b1;
    logic cke, wbuf_in_ready, arr_valid, write_busy, refresh_busy, refresh_pulse, self_refresh;
    sdwpr_cmd_pins_t cmd_pins;
    sdwpr_wbeat_t wbeat;
    sdwpr_arr_wr_t arr_wr, exp_w;
    logic [7:0] bank_open;
    logic [12:0] refresh_row, row0;
    logic a12;
    int n_fail = 0;
    int checked = 0;
    int n_pulse = 0;
    int p0;
    always #10 sys_clk = ~sys_clk;
    sdwpr_ctrl_model sdwpr_ctrl_model_i (.sys_clk(sys_clk), .cke(cke), .cmd_pins(cmd_pins),
        .wbeat(wbeat));
    sdwpr_core sdwpr_core_i (.sys_clk(sys_clk), .reset_n(reset_n), .cke(cke),
        .cmd_pins(cmd_pins), .wbeat(wbeat), .otf_enable(otf_enable), .fixed_chop(fixed_chop),
        .wbuf_in_ready(wbuf_in_ready), .arr_valid(arr_valid), .arr_ready(arr_ready),
        .arr_wr(arr_wr), .bank_open(bank_open), .write_busy(write_busy),
        .refresh_busy(refresh_busy), .refresh_pulse(refresh_pulse),
        .refresh_row(refresh_row), .self_refresh(self_refresh));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic done(input string name);
        sdwpr_ctrl_model_i.idle(4);
        chk("pending words", 0, sdwpr_ctrl_model_i.exp_q.size());
        $display("test %s finished, mismatches so far %0d", name, n_fail);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Oldest noted word against each word the array accepts
    always @(posedge sys_clk) begin
        if (refresh_pulse === 1'b1)
            n_pulse <= n_pulse + 1;
        if (reset_n && arr_valid === 1'b1 && arr_ready === 1'b1) begin
            if (sdwpr_ctrl_model_i.exp_q.size() == 0) begin
                checked++;
                n_fail++;
                $display("[FAIL] arr_wr expected none seen %h", arr_wr);
            end else begin
                exp_w = sdwpr_ctrl_model_i.exp_q.pop_front();
                chk("arr_wr", 64'(exp_w), 64'(arr_wr));
            end
        end
    end
    initial begin
        #400000;
        n_fail++;
        $display("watchdog expired");
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(59));
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("wbuf_in_ready", 1, wbuf_in_ready);
        chk("bank_open", 0, bank_open);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        sdwpr_ctrl_model_i.wake();
        sdwpr_ctrl_model_i.idle(3);
        sdwpr_ctrl_model_i.act(3'h1, 14'($urandom));
        sdwpr_ctrl_model_i.act(3'h2, 14'($urandom));
        @(negedge sys_clk);
        chk("bank_open", 8'h06, bank_open);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            otf_enable <= (k < 2);
            fixed_chop <= (k == 2);
            a12 = (k == 1 || k == 2);
            sdwpr_ctrl_model_i.wr(3'(1 + k % 2), 10'($urandom_range(0, 1000)), 1'b0, a12,
                (k % 2) ? 8 : 4, 99, 1'b1);
        end
        done("burst_lengths");
        sdwpr_ctrl_model_i.wr(3'h5, 10'h000, 1'b0, 1'b1, 8, 99, 1'b1);
        sdwpr_ctrl_model_i.wr(3'h2, 10'h010, 1'b1, 1'b1, 8, 99, 1'b1);
        sdwpr_ctrl_model_i.wr(3'h1, 10'h3F0, 1'b0, 1'b1, 8, 99, 1'b1);
        sdwpr_ctrl_model_i.idle(2);
        @(negedge sys_clk);
        chk("bank_open", 8'h02, bank_open);
        done("autoprecharge");
        sdwpr_ctrl_model_i.act(3'h3, 14'($urandom));
        sdwpr_ctrl_model_i.act(3'h4, 14'($urandom));
        sdwpr_ctrl_model_i.pre(3'h3, 1'b0);
        @(negedge sys_clk);
        chk("bank_open", 8'h12, bank_open);
        sdwpr_ctrl_model_i.pre(3'h5, 1'b0);
        @(negedge sys_clk);
        chk("bank_open", 8'h12, bank_open);
        sdwpr_ctrl_model_i.pre(3'h3, 1'b1);
        @(negedge sys_clk);
        chk("bank_open", 8'h00, bank_open);
        done("precharge");
        sdwpr_ctrl_model_i.act(3'h0, 14'($urandom));
        @(posedge sys_clk);
        arr_ready <= 1'b0;
        sdwpr_ctrl_model_i.wr(3'h0, 10'h020, 1'b0, 1'b1, 8, 2, 1'b0);
        @(negedge sys_clk);
        chk("wbuf_in_ready", 0, wbuf_in_ready);
        chk("arr_valid", 1, arr_valid);
        chk("write_busy", 0, write_busy);
        @(posedge sys_clk);
        arr_ready <= 1'b1;
        done("buffer_fill");
        row0 = refresh_row;
        p0 = n_pulse;
        sdwpr_ctrl_model_i.refr();
        sdwpr_ctrl_model_i.refr();
        @(negedge sys_clk);
        chk("refresh_busy", 1, refresh_busy);
        chk("refresh pulses", 2, n_pulse - p0);
        chk("refresh_row", 13'(row0 + 2), refresh_row);
        done("refresh");
        row0 = refresh_row;
        p0 = n_pulse;
        sdwpr_ctrl_model_i.sref();
        sdwpr_ctrl_model_i.idle(800);
        @(negedge sys_clk);
        chk("self_refresh", 1, self_refresh);
        sdwpr_ctrl_model_i.wake();
        sdwpr_ctrl_model_i.idle(512);
        @(negedge sys_clk);
        chk("refresh_busy", 0, refresh_busy);
        chk("self_refresh", 0, self_refresh);
        chk("refresh pulses", 3, n_pulse - p0);
        chk("refresh_row", 13'(row0 + 3), refresh_row);
        sdwpr_ctrl_model_i.act(3'h6, 14'($urandom));
        sdwpr_ctrl_model_i.wr(3'h6, 10'h100, 1'b1, 1'b0, 8, 99, 1'b1);
        done("self_refresh");
        close_out();
    end
endmodule
`default_nettype wire

// File: tb/sdwpr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdwpr_params.svh"
module sdwpr_ctrl_model
    import sdwpr_pkg::*;
(
    input wire logic sys_clk,
    output logic cke,
    output sdwpr_cmd_pins_t cmd_pins,
    output sdwpr_wbeat_t wbeat
);
    sdwpr_arr_wr_t exp_q[$];
    logic [`SDWPR_ROW_W-1:0] open_row [8];
    logic [7:0] is_open;
    initial begin
        cke = 1'b0;
        cmd_pins = '1;
        wbeat = '0;
        is_open = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Deselect, with junk on every line the device must ignore
    function automatic sdwpr_cmd_pins_t desel();
        logic [31:0] r;
        r = $urandom;
        desel = r[$bits(sdwpr_cmd_pins_t)-1:0];
        desel.cs_n = 1'b1;
    endfunction
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            cmd_pins <= desel();
            wbeat <= {8'($urandom), 1'b0};
        end
    endtask
    task automatic wake();
        @(posedge sys_clk);
        cke <= 1'b1;
    endtask
    task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [13:0] a);
        @(posedge sys_clk);
        cmd_pins <= {1'b0, rcw, ba, a};
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic act(input logic [2:0] ba, input logic [13:0] row);
        cmd(3'b011, ba, row);
        open_row[ba] = row;
        is_open[ba] = 1'b1;
        idle(2);
    endtask
    task automatic pre(input logic [2:0] ba, input logic all);
        cmd(3'b010, ba, {3'b000, all, 10'h000});
        if (all)
            is_open = 8'h00;
        else
            is_open[ba] = 1'b0;
        idle(2);
    endtask
    task automatic refr();
        if (is_open != 8'h00)
            pre(3'h0, 1'b1);
        cmd(3'b001, 3'($urandom), 14'($urandom));
        idle(8);
    endtask
    task automatic sref();
        @(posedge sys_clk);
        cke <= 1'b0;
        cmd_pins <= {1'b0, 3'b001, 3'($urandom), 14'($urandom)};
    endtask
    // Burst write; keep limits the words a stalled buffer can hold
    task automatic wr(input logic [2:0] ba, input logic [9:0] col, input logic ap,
                      input logic a12, input int nb, input int keep, input logic rmask);
        sdwpr_wbeat_t b;
        int kept;
        kept = 0;
        cmd(3'b100, ba, {1'b0, a12, 1'b0, ap, col});
        for (int i = 0; i < nb; i++) begin
            b.data = 8'($urandom);
            b.write_byte_mask = rmask & 1'($urandom);
            @(posedge sys_clk);
            cmd_pins <= desel();
            wbeat <= b;
            if (!b.write_byte_mask && is_open[ba] && kept < keep) begin
                exp_q.push_back('{ba, open_row[ba], col + 10'(i), b.data});
                kept++;
            end
        end
        if (ap)
            is_open[ba] = 1'b0;
        idle(1);
    endtask
endmodule
`default_nettype wire
